// ==== ebpm_mem_model.sv ====
// external memory partner on the multiplexed bus, resolving pin levels
module ebpm_mem_model (
  input wire logic clk,
  input wire logic [87:0] dev_out,
  input wire logic [87:0] dev_oe,
  input wire logic [87:0] ext,
  output logic [87:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] adr_q = 8'h00;
  logic [15:0] last_q = 16'h0000;
  // address byte on the third port (A16-23 under layout A, A0-7 under layout B) taken while ale is high
  always_ff @(posedge clk) begin
    if (dev_out[26] && dev_oe[26]) begin
      adr_q <= dev_out[23:16];
    end
    last_q <= (dev_out[23:8] & dev_oe[23:8]) | (last_q & ~dev_oe[23:8]);
  end
  // answers once ale falls; otherwise the released bus shows the inverse of its last level
  always_comb begin
    pin = ext;
    pin[23:8] = (dev_oe[26] && !dev_out[26]) ? {adr_q ^ 8'h5A, ~adr_q} : ~last_q;
    pin = (pin & ~dev_oe) | (dev_out & dev_oe);
  end
endmodule : ebpm_mem_model

// ==== ebpm_pkg.sv ====
// package of constants, types and register layout for the external bus pin mux
package ebpm_pkg;

  // ----------------------------------------------------------------
  // register map (word offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_LATCH_BASE = 6'h00;
  localparam logic [5:0] ADDR_DIR_BASE = 6'h10;
  localparam logic [5:0] ADDR_PERIPH_EN = 6'h20;
  localparam logic [5:0] ADDR_MODE_STAT = 6'h21;
  localparam logic [5:0] ADDR_P42_IO = 6'h22;
  localparam int NUM_PORTS = 11;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [15:0] PERIPH_EN_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // port indices
  // ----------------------------------------------------------------
  localparam int PORT_ADDR_LO = 0;
  localparam int PORT_ADDR_HI = 1;
  localparam int PORT_DATA_LO = 2;
  localparam int PORT_CTRL = 3;
  localparam int PORT_HOLD = 4;
  localparam int PORT_TIMA = 5;
  localparam int PORT_TIMB = 6;
  localparam int PORT_ANALOG = 7;
  localparam int PORT_SERIAL = 8;
  localparam int PORT_OUTONLY = 9;
  localparam int PORT_KEY = 10;

  // peripheral enable bit positions
  localparam int PEN_TIMA = 0;
  localparam int PEN_TIMB = 1;
  localparam int PEN_ANALOG = 2;
  localparam int PEN_SUBOSC = 3;
  localparam int PEN_SERIAL = 4;
  localparam int PEN_SERIAL3 = 5;
  localparam int PEN_KEY = 6;

  // address reach in bits per layout
  localparam int ADDR_BITS_A = 24;
  localparam int ADDR_BITS_B = 20;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXPAND = 2'b01,
    MODE_MPU = 2'b10
  } ebpm_mode_t;

  typedef struct packed {
    ebpm_mode_t mode;
    logic bus8;
    logic layout_a;
  } ebpm_cfg_t;

  // bus-side signals from the core's bus unit
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic data_oe;
    logic addr_phase;
    logic rd_wr_n;
    logic byte_high_enable;
    logic ale;
    logic hold_acknowledge;
    logic write_enable_low_byte;
    logic write_enable_high_byte;
    logic read_enable_strobe;
    logic sampling_strobe;
    logic [4:0] chip_sel;
    logic int_bus_enable;
    logic sys_clk_out;
  } ebpm_bus_t;

  // peripheral outputs offered to the pins
  typedef struct packed {
    logic [7:0] tima_out;
    logic [7:0] tima_oe;
    logic [7:0] timb_out;
    logic [7:0] timb_oe;
    logic [7:0] ser_out;
    logic [7:0] ser_oe;
    logic [3:0] ser3_out;
    logic [3:0] ser3_oe;
    logic sub_osc_output;
    logic sub_clk;
  } ebpm_periph_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } ebpm_pin_t;

endpackage : ebpm_pkg

// ==== ebpm_port.sv ====
// one general port: latch, direction register and pin drive selection
module ebpm_port
  import ebpm_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic WR_LATCH,
  input wire logic WR_DIR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] ALT_SEL,
  input wire logic [7:0] ALT_OUT,
  input wire logic [7:0] ALT_OE,
  output ebpm_pin_t PIN,
  output logic [7:0] LATCH,
  output logic [7:0] DIR
);
  logic [7:0] latch_q;
  logic [7:0] dir_q;

  // ----------------------------------------------------------------
  // port latch and direction
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      latch_q <= LATCH_RESET;
    end else if (CE && WR_LATCH) begin
      latch_q <= WDATA;
    end
  end

  // every pin is an input after reset
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dir_q <= DIR_RESET;
    end else if (CE && WR_DIR) begin
      dir_q <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // pin drive: alternate function per bit, else general I/O
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PIN <= '0;
    end else if (CE) begin
      PIN.out <= (ALT_SEL & ALT_OUT) | (~ALT_SEL & latch_q);
      PIN.oe <= (ALT_SEL & ALT_OE) | (~ALT_SEL & dir_q);
    end
  end

  assign LATCH = latch_q;
  assign DIR = dir_q;
endmodule // ebpm_port

// ==== ebpm_sync.sv ====
// two-flop synchroniser for pin inputs
module ebpm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      meta_q <= '0;
      Q <= '0;
    end else if (CE) begin
      meta_q <= D;
      Q <= meta_q;
    end
  end
endmodule // ebpm_sync

// ==== ebpm_top.sv ====
// top of the external bus pin-function multiplexer
// ----------------------------------------------------------------
// Overview of operation
// - width strap low gives 16-bit external data, high gives 8-bit
// - layout strap high selects layout A, low selects layout B
// - reset input low puts the whole block into reset
// - single-chip ports have per-pin direction bits, all inputs after reset
// - layout A: first port drives address bits 0 to 7
// - layout B: first port drives five chip selects, sampling strobe, A16, A17
// - second port: data 8-15 shared with address 8-15, address only if 8-bit
// - third port shares data 0-7 with address 16-23 (A) or 0-7 (B)
// - four-bit port: rw, bhe, ale, hold_acknowledge (A); wel, weh, ale, hold_acknowledge (B)
// - fifth port: hold request, ready inputs, clock out; expansion may keep I/O
// - enable pin shows internal access, or read strobe under layout B in expansion and microprocessor modes
// - output-only port floats after reset, drives once its latch is written
// - sixth and seventh ports double as timer, interrupt and sub-clock pins
// - eighth port doubles as analog inputs, top two as sub-oscillator
// - ninth port doubles as first and second serial unit pins
// - last port upper four pins double as key interrupt inputs
// - address reach 16 Mbytes under layout A, 1 Mbyte under layout B
// ----------------------------------------------------------------
module ebpm_top
  import ebpm_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic PROCESSOR_MODE_STRAP,
  input wire logic WIDTH_STRAP,
  input wire logic BUS_LAYOUT_STRAP,
  input wire logic MEM_EXPAND_REQ,
  input wire logic [5:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire ebpm_bus_t BUS,
  input wire ebpm_periph_t PERIPH,
  input wire logic [87:0] PIN_IN,
  output logic [87:0] PIN_OUT,
  output logic [87:0] PIN_OE,
  output logic [87:0] PIN_IN_SYNC,
  output logic [15:0] BUS_RDATA,
  output logic HOLD_REQUEST,
  output logic READY,
  output logic [2:0] EXTERNAL_INTERRUPT_INPUTS,
  output logic [3:0] KEY_INTERRUPT_INPUTS,
  output logic SUB_OSC_INPUT,
  output logic ENABLE_OUT,
  output logic [23:0] ADDR_MASK
);
  import ebpm_pkg::*;

  ebpm_cfg_t cfg_q;
  logic cfg_taken_q;
  logic [1:0] warm_q;
  logic [2:0] strap_sync;
  logic [87:0] pin_sync;
  logic [15:0] periph_en_q;
  logic p42_io_q;
  logic [NUM_PORTS-1:0] outonly_written_q;
  logic [7:0] alt_sel [NUM_PORTS];
  logic [7:0] alt_out [NUM_PORTS];
  logic [7:0] alt_oe [NUM_PORTS];
  logic [7:0] latch_v [NUM_PORTS];
  logic [7:0] dir_v [NUM_PORTS];
  ebpm_pin_t pin_v [NUM_PORTS];
  logic ext_bus;
  logic [23:0] ext_addr;

  function automatic logic is_ext(input ebpm_mode_t m);
    return m != MODE_SINGLE;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  ebpm_sync #(.WIDTH(3)) u_strap_sync (
    .SYS_CLK(SYS_CLK),
    .RESETN(RESETN),
    .CE(CE),
    .D({PROCESSOR_MODE_STRAP, WIDTH_STRAP, BUS_LAYOUT_STRAP}),
    .Q(strap_sync)
  );

  ebpm_sync #(.WIDTH(88)) u_pin_sync (
    .SYS_CLK(SYS_CLK),
    .RESETN(RESETN),
    .CE(CE),
    .D(PIN_IN),
    .Q(pin_sync)
  );

  // ----------------------------------------------------------------
  // synchroniser warm-up
  // ----------------------------------------------------------------
  // the strap flops hold their reset zeros for two edges after release
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      warm_q <= 2'b00;
    end else if (CE) begin
      warm_q <= {warm_q[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  // straps are read once; later changes are ignored so pins never re-route mid-run
  // the expansion request is an on-chip mode bit, so no synchroniser
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_q <= '{mode: MODE_SINGLE, bus8: 1'b1, layout_a: 1'b1};
      cfg_taken_q <= 1'b0;
    end else if (CE && !cfg_taken_q && warm_q[1]) begin
      cfg_taken_q <= 1'b1;
      cfg_q.mode <= strap_sync[2] ? MODE_MPU :
                    (MEM_EXPAND_REQ ? MODE_EXPAND : MODE_SINGLE);
      cfg_q.bus8 <= strap_sync[1];
      cfg_q.layout_a <= strap_sync[0];
    end
  end

  assign ext_bus = is_ext(cfg_q.mode) && cfg_taken_q;
  // layout B reaches only 20 address bits
  assign ADDR_MASK = cfg_q.layout_a ? 24'hFFFFFF : 24'h0FFFFF;
  assign ext_addr = BUS.addr & ADDR_MASK;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      periph_en_q <= PERIPH_EN_RESET;
      p42_io_q <= 1'b0;
    end else if (CE && REG_WR) begin
      if (REG_ADDR == ADDR_PERIPH_EN) begin
        periph_en_q <= REG_WDATA;
      end
      if (REG_ADDR == ADDR_P42_IO) begin
        p42_io_q <= REG_WDATA[0];
      end
    end
  end

  // output-only port stays floating until its latch is written
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      outonly_written_q <= '0;
    end else if (CE && REG_WR && REG_ADDR == ADDR_LATCH_BASE + 6'(PORT_OUTONLY)) begin
      outonly_written_q[PORT_OUTONLY] <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 16'h0000;
    end else if (CE) begin
      REG_RDATA <= 16'h0000;
      if (REG_RD) begin
        if (REG_ADDR < ADDR_LATCH_BASE + 6'(NUM_PORTS)) begin
          REG_RDATA <= {8'h00, pin_sync[8*REG_ADDR[3:0] +: 8]};
        end else if (REG_ADDR >= ADDR_DIR_BASE && REG_ADDR < ADDR_DIR_BASE + 6'(NUM_PORTS)) begin
          REG_RDATA <= {8'h00, dir_v[REG_ADDR[3:0]]};
        end else if (REG_ADDR == ADDR_PERIPH_EN) begin
          REG_RDATA <= periph_en_q;
        end else if (REG_ADDR == ADDR_MODE_STAT) begin
          REG_RDATA <= {11'h000, cfg_taken_q, cfg_q};
        end else if (REG_ADDR == ADDR_P42_IO) begin
          REG_RDATA <= {15'h0000, p42_io_q};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // alternate function selection
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      alt_sel[i] = 8'h00;
      alt_out[i] = 8'h00;
      alt_oe[i] = 8'h00;
    end
    if (ext_bus) begin
      alt_sel[PORT_ADDR_LO] = 8'hFF;
      alt_oe[PORT_ADDR_LO] = 8'hFF;
      if (cfg_q.layout_a) begin
        alt_out[PORT_ADDR_LO] = ext_addr[7:0];
      end else begin
        alt_out[PORT_ADDR_LO] = {ext_addr[17:16], BUS.sampling_strobe, BUS.chip_sel};
      end
      alt_sel[PORT_ADDR_HI] = 8'hFF;
      if (cfg_q.bus8 || BUS.addr_phase) begin
        alt_out[PORT_ADDR_HI] = ext_addr[15:8];
        alt_oe[PORT_ADDR_HI] = 8'hFF;
      end else begin
        alt_out[PORT_ADDR_HI] = BUS.wdata[15:8];
        alt_oe[PORT_ADDR_HI] = {8{BUS.data_oe}};
      end
      alt_sel[PORT_DATA_LO] = 8'hFF;
      if (BUS.addr_phase) begin
        alt_out[PORT_DATA_LO] = cfg_q.layout_a ? ext_addr[23:16] : ext_addr[7:0];
        alt_oe[PORT_DATA_LO] = 8'hFF;
      end else begin
        alt_out[PORT_DATA_LO] = BUS.wdata[7:0];
        alt_oe[PORT_DATA_LO] = {8{BUS.data_oe}};
      end
      alt_sel[PORT_CTRL] = 8'h0F;
      alt_oe[PORT_CTRL] = 8'h0F;
      if (cfg_q.layout_a) begin
        alt_out[PORT_CTRL] = {4'h0, BUS.hold_acknowledge, BUS.ale,
                              BUS.byte_high_enable, BUS.rd_wr_n};
      end else begin
        alt_out[PORT_CTRL] = {4'h0, BUS.hold_acknowledge, BUS.ale,
                              BUS.write_enable_high_byte, BUS.write_enable_low_byte};
      end
      // the clock pin may be reclaimed as I/O only in expansion mode
      alt_sel[PORT_HOLD] = (cfg_q.mode == MODE_EXPAND && p42_io_q) ? 8'h03 : 8'h07;
      alt_out[PORT_HOLD] = {5'h00, BUS.sys_clk_out, 2'b00};
      alt_oe[PORT_HOLD] = {5'h00, !(cfg_q.mode == MODE_EXPAND && p42_io_q), 2'b00};
    end
    if (periph_en_q[PEN_TIMA]) begin
      alt_sel[PORT_TIMA] = PERIPH.tima_oe;
      alt_out[PORT_TIMA] = PERIPH.tima_out;
      alt_oe[PORT_TIMA] = PERIPH.tima_oe;
    end
    if (periph_en_q[PEN_TIMB]) begin
      alt_sel[PORT_TIMB] = PERIPH.timb_oe;
      alt_out[PORT_TIMB] = {PERIPH.sub_clk, PERIPH.timb_out[6:0]};
      alt_oe[PORT_TIMB] = PERIPH.timb_oe;
    end
    if (periph_en_q[PEN_ANALOG]) begin
      alt_sel[PORT_ANALOG] = 8'h3F;
    end
    if (periph_en_q[PEN_SUBOSC]) begin
      alt_sel[PORT_ANALOG][7:6] = 2'b11;
      alt_out[PORT_ANALOG][6] = PERIPH.sub_osc_output;
      alt_oe[PORT_ANALOG][6] = 1'b1;
    end
    if (periph_en_q[PEN_SERIAL]) begin
      alt_sel[PORT_SERIAL] = PERIPH.ser_oe;
      alt_out[PORT_SERIAL] = PERIPH.ser_out;
      alt_oe[PORT_SERIAL] = PERIPH.ser_oe;
    end
    alt_sel[PORT_OUTONLY] = 8'hFF;
    alt_out[PORT_OUTONLY] = latch_v[PORT_OUTONLY];
    alt_oe[PORT_OUTONLY] = {8{outonly_written_q[PORT_OUTONLY]}};
    if (periph_en_q[PEN_SERIAL3]) begin
      alt_out[PORT_OUTONLY][3:0] = PERIPH.ser3_out;
      alt_oe[PORT_OUTONLY][3:0] = PERIPH.ser3_oe;
    end
    if (periph_en_q[PEN_KEY]) begin
      alt_sel[PORT_KEY] = 8'hF0;
    end
  end

  // ----------------------------------------------------------------
  // port instances
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    ebpm_port u_port (
      .SYS_CLK(SYS_CLK),
      .RESETN(RESETN),
      .CE(CE),
      .WR_LATCH(REG_WR && REG_ADDR == ADDR_LATCH_BASE + 6'(p)),
      .WR_DIR(REG_WR && REG_ADDR == ADDR_DIR_BASE + 6'(p)),
      .WDATA(REG_WDATA[7:0]),
      .ALT_SEL(alt_sel[p]),
      .ALT_OUT(alt_out[p]),
      .ALT_OE(alt_oe[p]),
      .PIN(pin_v[p]),
      .LATCH(latch_v[p]),
      .DIR(dir_v[p])
    );
    assign PIN_OUT[8*p +: 8] = pin_v[p].out;
    assign PIN_OE[8*p +: 8] = pin_v[p].oe;
  end

  // ----------------------------------------------------------------
  // inputs routed back to the core and peripherals
  // ----------------------------------------------------------------
  assign PIN_IN_SYNC = pin_sync;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BUS_RDATA <= 16'h0000;
      HOLD_REQUEST <= 1'b0;
      READY <= 1'b1;
      ENABLE_OUT <= 1'b0;
      EXTERNAL_INTERRUPT_INPUTS <= 3'h0;
      KEY_INTERRUPT_INPUTS <= 4'h0;
      SUB_OSC_INPUT <= 1'b0;
    end else if (CE) begin
      BUS_RDATA <= {cfg_q.bus8 ? 8'h00 : pin_sync[8*PORT_ADDR_HI +: 8],
                    pin_sync[8*PORT_DATA_LO +: 8]};
      HOLD_REQUEST <= ext_bus && pin_sync[8*PORT_HOLD];
      READY <= !ext_bus || pin_sync[8*PORT_HOLD + 1];
      ENABLE_OUT <= (ext_bus && !cfg_q.layout_a) ? BUS.read_enable_strobe
                                                 : BUS.int_bus_enable;
      EXTERNAL_INTERRUPT_INPUTS <= pin_sync[8*PORT_TIMB + 2 +: 3];
      KEY_INTERRUPT_INPUTS <= periph_en_q[PEN_KEY] ? pin_sync[8*PORT_KEY + 4 +: 4] : 4'h0;
      SUB_OSC_INPUT <= periph_en_q[PEN_SUBOSC] && pin_sync[8*PORT_ANALOG + 7];
    end
  end
endmodule // ebpm_top

// ==== ebpm_top_sva.sv ====
// assertions on the ports of the external bus pin mux
module ebpm_top_sva (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [5:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [87:0] PIN_IN_SYNC,
  input wire logic [87:0] PIN_OUT,
  input wire logic [87:0] PIN_OE,
  input wire logic [23:0] ADDR_MASK
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  logic [2:0] age_q;
  // ------------------------------------------------------------
  // edges since release
  // ------------------------------------------------------------
  // saturates well after strap capture, so a later change is a fault
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      age_q <= 3'h0;
    end else if (CE && age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  rst_quiet_a: assert property ($rose(RESETN) |-> PIN_OE == 88'h0)
    else $error("pins driven on leaving reset");
  rd_idle_a: assert property (!$past(REG_RD && CE) && $past(CE) |-> REG_RDATA == 16'h0)
    else $error("read data outside its cycle");
  port_read_a: assert property (REG_RD && CE && REG_ADDR == 6'h00 |=>
    REG_RDATA == {8'h00, $past(PIN_IN_SYNC[7:0])}) else $error("port read wrong");
  dir_write_a: assert property (REG_WR && CE && REG_ADDR == 6'h1A ##1 CE |=>
    PIN_OE[83:80] == $past(REG_WDATA[3:0], 2)) else $error("direction not applied");
  p9_write_a: assert property (REG_WR && CE && REG_ADDR == 6'h09 ##1 CE |=>
    PIN_OUT[79:76] == $past(REG_WDATA[7:4], 2) && PIN_OE[79:76] == 4'hF)
    else $error("output port not driven");
  p9_hold_a: assert property ($past(PIN_OE[79]) |-> PIN_OE[79])
    else $error("output port floated again");
  p9_whole_a: assert property (PIN_OE[79:76] == 4'h0 || PIN_OE[79:76] == 4'hF)
    else $error("output port partly driven");
  mask_value_a: assert property (ADDR_MASK == 24'hFFFFFF || ADDR_MASK == 24'h0FFFFF)
    else $error("address reach wrong");
  mask_static_a: assert property (age_q == 3'h7 |-> $stable(ADDR_MASK))
    else $error("layout changed after capture");
  cover property (REG_WR && REG_ADDR == 6'h09);
  cover property (REG_RD && REG_ADDR == 6'h21);
  cover property ($rose(RESETN));
endmodule : ebpm_top_sva

bind ebpm_top ebpm_top_sva u_ebpm_top_sva (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CE(CE),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .PIN_IN_SYNC(PIN_IN_SYNC), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .ADDR_MASK(ADDR_MASK));

// ==== ebpm_top_tb.sv ====
// self-checking testbench for the external bus pin mux
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ebpm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ebpm_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, mode_s = 0, width_s = 0, layout_s = 0, mexp = 0;
  logic reg_wr = 0, reg_rd = 0, hold, rdy, sosc, en_o;
  logic [5:0] ra = 6'h00;
  logic [15:0] wd = 16'h0000, rdata, brd;
  logic [3:0] kint;
  logic [23:0] amask;
  logic [87:0] ext = 88'h9000008000000100000096, pin_in, pout, poe;
  ebpm_bus_t bus = '0;
  ebpm_periph_t per = '1;
  int mismatches = 0, samples_checked = 0;
  initial begin
    forever #2 clk = ~clk;
  end
  ebpm_top u_ebpm_top (.SYS_CLK(clk), .RESETN(rst_n), .CE(ce), .PROCESSOR_MODE_STRAP(mode_s),
    .WIDTH_STRAP(width_s), .BUS_LAYOUT_STRAP(layout_s), .MEM_EXPAND_REQ(mexp), .REG_ADDR(ra),
    .REG_WDATA(wd), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .BUS(bus),
    .PERIPH(per), .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE(poe), .PIN_IN_SYNC(),
    .BUS_RDATA(brd), .HOLD_REQUEST(hold), .READY(rdy), .EXTERNAL_INTERRUPT_INPUTS(),
    .KEY_INTERRUPT_INPUTS(kint), .SUB_OSC_INPUT(sosc), .ENABLE_OUT(en_o), .ADDR_MASK(amask));
  ebpm_mem_model u_ebpm_mem_model (.clk(clk), .dev_out(pout), .dev_oe(poe), .ext(ext),
    .pin(pin_in));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk) begin ra <= a; wd <= v; reg_wr <= 1'b1; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk) begin ra <= a; reg_rd <= 1'b1; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  // restart moves the straps only while reset is held, as a board tie would
  task automatic restart(input logic m, input logic w, input logic l, input logic x);
    @(posedge clk) begin rst_n <= 1'b0; mode_s <= m; width_s <= w; layout_s <= l; mexp <= x; end
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task final_report;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    final_report;
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    restart(1'b0, 1'b0, 1'b1, 1'b0);
    `CHK(poe, 88'h0)
    wr_reg(6'h10, 16'h00A5);
    wr_reg(6'h00, 16'h003C);
    wr_reg(6'h09, 16'h0055);
    wr_reg(6'h1A, 16'h000F);
    wr_reg(6'h3F, 16'hFFFF);
    settle;
    `CHK(poe[7:0], 8'hA5)
    `CHK(pout[7:0] & 8'hA5, 8'h24)
    `CHK({poe[79:72], pout[79:72]}, 16'hFF55)
    `CHK(poe[47:40], 8'h00)
    // a write made while the clock enable is low must leave no trace
    @(posedge clk) ce <= 1'b0;
    wr_reg(6'h10, 16'h00FF);
    @(posedge clk) ce <= 1'b1;
    settle;
    `CHK(poe[7:0], 8'hA5)
    rd_reg(6'h00, 16'h0036);
    rd_reg(6'h3F, 16'h0000);
    wr_reg(6'h20, 16'h007F);
    settle;
    `CHK(poe[47:40], 8'hFF)
    `CHK(poe[71:64], 8'hFF)
    `CHK({pout[62], sosc}, 2'b11)
    `CHK(kint, 4'h9)
    $display("single chip test finished");
    restart(1'b0, 1'b0, 1'b1, 1'b1);
    @(posedge clk) bus <= '{addr: 24'hABCDEF, addr_phase: 1'b1, byte_high_enable: 1'b1,
      hold_acknowledge: 1'b1, sys_clk_out: 1'b1, int_bus_enable: 1'b1, default: '0};
    settle;
    `CHK({poe[23:0], pout[23:0]}, 48'hFFFFFF_ABCDEF)
    `CHK(pout[27:24], 4'hA)
    `CHK({poe[34:32], pout[34]}, 4'b1001)
    `CHK({hold, rdy}, 2'b10)
    `CHK(en_o, 1'b1)
    `CHK(amask, 24'hFFFFFF)
    rd_reg(6'h21, 16'h0015);
    @(posedge clk) begin bus.addr_phase <= 1'b0; bus.data_oe <= 1'b1; bus.wdata <= 16'h1234; end
    settle;
    `CHK({pout[15:8], pout[23:16]}, 16'h1234)
    @(posedge clk) begin bus.addr_phase <= 1'b1; bus.data_oe <= 1'b0; bus.ale <= 1'b1; end
    settle;
    @(posedge clk) begin bus.addr_phase <= 1'b0; bus.ale <= 1'b0; end
    settle;
    `CHK(brd, 16'h54F1)
    wr_reg(6'h22, 16'h0001);
    wr_reg(6'h14, 16'h0004);
    settle;
    `CHK({poe[34], pout[34]}, 2'b10)
    @(posedge clk) begin layout_s <= 1'b0; width_s <= 1'b1; end
    settle;
    rd_reg(6'h21, 16'h0015);
    `CHK(amask, 24'hFFFFFF)
    $display("layout A expansion test finished");
    restart(1'b1, 1'b1, 1'b0, 1'b0);
    @(posedge clk) bus <= '{addr: 24'h02A5C3, chip_sel: 5'h15, sampling_strobe: 1'b1,
      addr_phase: 1'b1, write_enable_low_byte: 1'b1, ale: 1'b1, read_enable_strobe: 1'b1,
      default: '0};
    settle;
    `CHK(pout[15:0], 16'hA5B5)
    `CHK(pout[23:16], 8'hC3)
    `CHK(pout[27:24], 4'h5)
    `CHK(en_o, 1'b1)
    `CHK(amask, 24'h0FFFFF)
    rd_reg(6'h21, 16'h001A);
    @(posedge clk) begin bus.addr_phase <= 1'b0; bus.ale <= 1'b0; end
    settle;
    `CHK({poe[15:8], pout[15:8]}, 16'hFFA5)
    `CHK(brd, 16'h0099)
    $display("layout B microprocessor test finished");
    final_report;
  end
endmodule : ebpm_top_tb
